/* hdl/tmr8c_regs.vh */
`ifndef TMR8C_REGS_VH
`define TMR8C_REGS_VH
// Register byte offsets
`define TMR8C_OFS_CTRL_A 8'h00
`define TMR8C_OFS_CTRL_B 8'h04
`define TMR8C_OFS_COUNT 8'h08
`define TMR8C_OFS_CMP_A 8'h0C
`define TMR8C_OFS_CMP_B 8'h10
`define TMR8C_OFS_FLAG 8'h14
`define TMR8C_OFS_MASK 8'h18
`define TMR8C_OFS_ASYNC 8'h1C
`define TMR8C_OFS_POWER 8'h20
// timer_control_a fields
`define TMR8C_WM_LO_LSB 0
`define TMR8C_COMB_LSB 4
`define TMR8C_COMA_LSB 6
// timer_control_b fields
`define TMR8C_CS_LSB 0
`define TMR8C_WM_HI_BIT 3
`define TMR8C_FORCE_B_BIT 6
`define TMR8C_FORCE_A_BIT 7
// Flag and mask bit positions
`define TMR8C_OVF_BIT 0
`define TMR8C_MA_BIT 1
`define TMR8C_MB_BIT 2
// async_status_reg and power_reduction_reg bits
`define TMR8C_ASYNC_BIT 0
`define TMR8C_PWROFF_BIT 0
// Reset values
`define TMR8C_RST_BYTE 8'h00
`define TMR8C_RST_PWROFF 1'b0
// Counter extremes
`define TMR8C_BOTTOM 8'h00
`define TMR8C_MAX 8'hFF
// Waveform modes
`define TMR8C_WM_NORMAL 3'h0
`define TMR8C_WM_PC_FF 3'h1
`define TMR8C_WM_CTC 3'h2
`define TMR8C_WM_FAST_FF 3'h3
`define TMR8C_WM_PC_A 3'h5
`define TMR8C_WM_FAST_A 3'h7
// Compare output modes
`define TMR8C_COM_OFF 2'h0
`define TMR8C_COM_TOGGLE 2'h1
`define TMR8C_COM_CLEAR 2'h2
`define TMR8C_COM_SET 2'h3
`endif

/* hdl/tmr8c_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "tmr8c_regs.vh"

// Overview of operation
// - Counter and both compare registers are eight bits wide
// - Every request shows in the flag register, each gated by its mask bit
// - Tick is the bus clock unless async select picks the oscillator pin
// - Clock select zero stops the counter completely
// - Software reads and writes the counter whether running or stopped
// - A counter write beats any clear, increment or decrement in that cycle
// - Each tick clears, increments or decrements by one per mode and direction
// - Three-bit wave mode: two low bits in control A, high bit in control B
// - 0x00 is BOTTOM, 0xFF is MAX; indications raised on reaching each
// - TOP is 0xFF or compare A depending on mode
// - Counter compared continuously against both compare registers
// - Match flag sets on the tick after the match
// - Enabled flag raises request; servicing clears the flag
// - Writing one clears a flag, writing zero leaves it
// - Compare registers double buffered in PWM modes only
// - Buffered value loads into active register only at TOP
// - Software reaches buffer when buffered, active register otherwise
// - Overflow flag sets per mode and serves as a request
// - Each compare output follows its match, wave mode and output mode field
// - Normal mode counts up, wraps 0xFF to 0x00, overflow with the zero
// - Clear-on-compare mode clears the counter on the tick after match A
// - A counter write blocks matches on the next tick, even when stopped
// - Force strobe updates outputs in non-PWM modes without flag or clear
module tmr8c_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire osc_pin_in,
  output reg osc_pin_out,
  input wire ack_overflow,
  input wire ack_match_a,
  input wire ack_match_b,
  output reg irq_overflow,
  output reg irq_match_a,
  output reg irq_match_b,
  output reg compare_out_a,
  output reg compare_out_b,
  output reg count_at_top,
  output reg count_at_bottom
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [7:0] timer_control_a;
  reg [2:0] clock_select_field;
  reg wave_mode_bit2;
  reg [7:0] count_value_reg;
  reg [7:0] compare_value_a;
  reg [7:0] compare_value_b;
  reg [7:0] buffer_a;
  reg [7:0] buffer_b;
  reg overflow_flag;
  reg match_flag_a;
  reg match_flag_b;
  reg [2:0] timer_irq_mask_reg;
  reg async_clock_select;
  reg timer_power_off_bit;
  reg count_down;
  reg match_block;
  reg osc_prev;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire setup = psel & ~penable;
  wire wr_done = psel & penable & pready & pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  wire sel_ctrl_a = (paddr[7:0] == `TMR8C_OFS_CTRL_A);
  wire sel_ctrl_b = (paddr[7:0] == `TMR8C_OFS_CTRL_B);
  wire sel_count = (paddr[7:0] == `TMR8C_OFS_COUNT);
  wire sel_cmp_a = (paddr[7:0] == `TMR8C_OFS_CMP_A);
  wire sel_cmp_b = (paddr[7:0] == `TMR8C_OFS_CMP_B);
  wire sel_flag = (paddr[7:0] == `TMR8C_OFS_FLAG);
  wire sel_mask = (paddr[7:0] == `TMR8C_OFS_MASK);
  wire sel_async = (paddr[7:0] == `TMR8C_OFS_ASYNC);
  wire sel_power = (paddr[7:0] == `TMR8C_OFS_POWER);
  wire mapped = (paddr[31:8] == 24'h000000) & (sel_ctrl_a | sel_ctrl_b | sel_count |
    sel_cmp_a | sel_cmp_b | sel_flag | sel_mask | sel_async | sel_power);
  wire wr_count = wr_done & mapped & sel_count;
  wire wr_ctrl_b = wr_done & mapped & sel_ctrl_b;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire [2:0] wave_mode_field = {wave_mode_bit2, timer_control_a[1:0]};
  wire [1:0] com_a = timer_control_a[`TMR8C_COMA_LSB+1:`TMR8C_COMA_LSB];
  wire [1:0] com_b = timer_control_a[`TMR8C_COMB_LSB+1:`TMR8C_COMB_LSB];
  wire mode_fast = (wave_mode_field == `TMR8C_WM_FAST_FF) |
    (wave_mode_field == `TMR8C_WM_FAST_A);
  wire mode_pc = (wave_mode_field == `TMR8C_WM_PC_FF) |
    (wave_mode_field == `TMR8C_WM_PC_A);
  wire mode_pwm = mode_fast | mode_pc;
  wire mode_ctc = (wave_mode_field == `TMR8C_WM_CTC);
  wire top_is_a = mode_ctc | (wave_mode_field == `TMR8C_WM_PC_A) |
    (wave_mode_field == `TMR8C_WM_FAST_A);
  // TOP choice per mode
  wire [7:0] top_value = top_is_a ? compare_value_a : `TMR8C_MAX;
  wire at_top = (count_value_reg == top_value);
  wire at_bottom = (count_value_reg == `TMR8C_BOTTOM);

  // ****************************************************************
  // Timer tick
  // ****************************************************************
  // Oscillator pin is taken as synchronous, so a plain edge detect is enough
  wire osc_rise = osc_pin_in & ~osc_prev;
  wire source_tick = async_clock_select ? osc_rise : 1'b1;
  // Prescaler lies outside this core: any nonzero selection passes the source
  wire timer_tick_clock = source_tick & (clock_select_field != 3'h0) &
    ~timer_power_off_bit;

  // Comparator, blocked for one tick after a counter write
  wire match_a = (count_value_reg == compare_value_a) & ~match_block;
  wire match_b = (count_value_reg == compare_value_b) & ~match_block;

  // ****************************************************************
  // Next counter value
  // ****************************************************************
  reg [7:0] next_count;
  reg next_down;
  reg ovf_event;
  reg reload_event;
  always @* begin
    next_count = count_value_reg;
    next_down = count_down;
    ovf_event = 1'b0;
    reload_event = 1'b0;
    if (mode_pc) begin
      // Dual slope: turn at TOP, overflow and turn at BOTTOM
      reload_event = at_top;
      if (at_top) begin
        next_down = 1'b1;
      end else if (at_bottom) begin
        next_down = 1'b0;
        ovf_event = 1'b1;
      end
      if (next_down) begin
        next_count = count_value_reg - 8'h01;
      end else begin
        next_count = count_value_reg + 8'h01;
      end
    end else if (mode_fast) begin
      next_down = 1'b0;
      reload_event = at_top;
      if (at_top) begin
        next_count = `TMR8C_BOTTOM;
        ovf_event = 1'b1;
      end else begin
        next_count = count_value_reg + 8'h01;
      end
    end else begin
      next_down = 1'b0;
      ovf_event = (count_value_reg == `TMR8C_MAX);
      if (mode_ctc & (count_value_reg == compare_value_a) & ~match_block) begin
        next_count = `TMR8C_BOTTOM;
      end else begin
        next_count = count_value_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Counter, direction and match blocking
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_reg <= `TMR8C_RST_BYTE;
      count_down <= 1'b0;
      match_block <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_pin_in;
      if (wr_count) begin
        count_value_reg <= wbyte;
        match_block <= 1'b1;
      end else if (timer_tick_clock) begin
        count_value_reg <= next_count;
        count_down <= next_down;
        match_block <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control registers and compare buffers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_a <= `TMR8C_RST_BYTE;
      clock_select_field <= 3'h0;
      wave_mode_bit2 <= 1'b0;
      compare_value_a <= `TMR8C_RST_BYTE;
      compare_value_b <= `TMR8C_RST_BYTE;
      buffer_a <= `TMR8C_RST_BYTE;
      buffer_b <= `TMR8C_RST_BYTE;
      timer_irq_mask_reg <= 3'h0;
      async_clock_select <= 1'b0;
      timer_power_off_bit <= `TMR8C_RST_PWROFF;
    end else begin
      if (wr_done & mapped & sel_ctrl_a) begin
        timer_control_a <= wbyte;
      end
      if (wr_ctrl_b) begin
        clock_select_field <= wbyte[`TMR8C_CS_LSB+2:`TMR8C_CS_LSB];
        wave_mode_bit2 <= wbyte[`TMR8C_WM_HI_BIT];
      end
      if (wr_done & mapped & sel_mask) begin
        timer_irq_mask_reg <= wbyte[2:0];
      end
      if (wr_done & mapped & sel_async) begin
        async_clock_select <= wbyte[`TMR8C_ASYNC_BIT];
      end
      if (wr_done & mapped & sel_power) begin
        timer_power_off_bit <= wbyte[`TMR8C_PWROFF_BIT];
      end
      // Buffer follows the bus; the active copy follows the buffer only at TOP
      if (wr_done & mapped & sel_cmp_a) begin
        buffer_a <= wbyte;
      end
      if (wr_done & mapped & sel_cmp_b) begin
        buffer_b <= wbyte;
      end
      if (mode_pwm) begin
        if (timer_tick_clock & reload_event) begin
          compare_value_a <= buffer_a;
          compare_value_b <= buffer_b;
        end
      end else begin
        if (wr_done & mapped & sel_cmp_a) begin
          compare_value_a <= wbyte;
        end
        if (wr_done & mapped & sel_cmp_b) begin
          compare_value_b <= wbyte;
        end
      end
    end
  end

  // ****************************************************************
  // Flags and interrupt requests
  // ****************************************************************
  // The match seen during the previous timer cycle is flagged at this tick
  wire set_ovf = timer_tick_clock & ovf_event & ~wr_count;
  wire set_ma = timer_tick_clock & match_a;
  wire set_mb = timer_tick_clock & match_b;
  wire clr_flag = wr_done & mapped & sel_flag;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
    end else begin
      // Set wins over either clear so no event is lost
      if (set_ovf) begin
        overflow_flag <= 1'b1;
      end else if (ack_overflow | (clr_flag & wbyte[`TMR8C_OVF_BIT])) begin
        overflow_flag <= 1'b0;
      end
      if (set_ma) begin
        match_flag_a <= 1'b1;
      end else if (ack_match_a | (clr_flag & wbyte[`TMR8C_MA_BIT])) begin
        match_flag_a <= 1'b0;
      end
      if (set_mb) begin
        match_flag_b <= 1'b1;
      end else if (ack_match_b | (clr_flag & wbyte[`TMR8C_MB_BIT])) begin
        match_flag_b <= 1'b0;
      end
    end
  end

  // Requests and extreme indications registered for clean outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_overflow <= 1'b0;
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
      count_at_top <= 1'b0;
      count_at_bottom <= 1'b0;
      osc_pin_out <= 1'b0;
    end else begin
      irq_overflow <= overflow_flag & timer_irq_mask_reg[`TMR8C_OVF_BIT];
      irq_match_a <= match_flag_a & timer_irq_mask_reg[`TMR8C_MA_BIT];
      irq_match_b <= match_flag_b & timer_irq_mask_reg[`TMR8C_MB_BIT];
      count_at_top <= (count_value_reg == `TMR8C_MAX);
      count_at_bottom <= at_bottom;
      // Inverting drive for the crystal, idle low when not in use
      osc_pin_out <= async_clock_select & ~osc_pin_in;
    end
  end

  // ****************************************************************
  // Waveform generator
  // ****************************************************************
  // Force strobes only act outside PWM and touch neither flag nor counter
  wire force_a = wr_ctrl_b & wbyte[`TMR8C_FORCE_A_BIT] & ~mode_pwm;
  wire force_b = wr_ctrl_b & wbyte[`TMR8C_FORCE_B_BIT] & ~mode_pwm;
  reg next_out_a;
  reg next_out_b;
  always @* begin
    next_out_a = compare_out_a;
    next_out_b = compare_out_b;
    if (!mode_pwm) begin
      if (set_ma | force_a) begin
        case (com_a)
          `TMR8C_COM_TOGGLE: next_out_a = ~compare_out_a;
          `TMR8C_COM_CLEAR: next_out_a = 1'b0;
          `TMR8C_COM_SET: next_out_a = 1'b1;
          default: next_out_a = compare_out_a;
        endcase
      end
      if (set_mb | force_b) begin
        case (com_b)
          `TMR8C_COM_TOGGLE: next_out_b = ~compare_out_b;
          `TMR8C_COM_CLEAR: next_out_b = 1'b0;
          `TMR8C_COM_SET: next_out_b = 1'b1;
          default: next_out_b = compare_out_b;
        endcase
      end
    end else if (timer_tick_clock) begin
      // PWM: clear/set on match, restore at BOTTOM or on the down slope
      if (set_ma) begin
        if (com_a == `TMR8C_COM_TOGGLE) begin
          next_out_a = wave_mode_bit2 ? ~compare_out_a : compare_out_a;
        end else if (com_a[1]) begin
          next_out_a = (mode_pc & count_down) ? ~com_a[0] : com_a[0];
        end
      end else if (mode_fast & reload_event & com_a[1]) begin
        next_out_a = ~com_a[0];
      end
      if (set_mb & com_b[1]) begin
        next_out_b = (mode_pc & count_down) ? ~com_b[0] : com_b[0];
      end else if (mode_fast & reload_event & com_b[1]) begin
        next_out_b = ~com_b[0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else begin
      compare_out_a <= next_out_a;
      compare_out_b <= next_out_b;
    end
  end

  // ****************************************************************
  // APB slave: no wait states, registered read data
  // ****************************************************************
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (sel_ctrl_a) rd_byte = timer_control_a;
    if (sel_ctrl_b) rd_byte = {4'h0, wave_mode_bit2, clock_select_field};
    if (sel_count) rd_byte = count_value_reg;
    if (sel_cmp_a) rd_byte = mode_pwm ? buffer_a : compare_value_a;
    if (sel_cmp_b) rd_byte = mode_pwm ? buffer_b : compare_value_b;
    if (sel_flag) rd_byte = {5'h00, match_flag_b, match_flag_a, overflow_flag};
    if (sel_mask) rd_byte = {5'h00, timer_irq_mask_reg};
    if (sel_async) rd_byte = {7'h00, async_clock_select};
    if (sel_power) rd_byte = {7'h00, timer_power_off_bit};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~mapped;
        prdata <= (mapped & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // tmr8c_core
`default_nettype wire

/* bench/tmr8c_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Port checker of the timer core
// ************************************
module tmr8c_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_pin_in,
  input wire logic osc_pin_out,
  input wire logic count_at_top,
  input wire logic count_at_bottom
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answer comes exactly one cycle after the setup edge
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && !penable && paddr[31:8] != 24'h0 |=> pslverr)
    else $error("unmapped access not refused");
  // Read data only in a read answer, and never wider than a byte
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data during write");
  a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7");
  a_top_not_bottom: assert property (!(count_at_top && count_at_bottom))
    else $error("top and bottom together");
  // Oscillator drive is high only if the pin was low one cycle earlier
  a_osc_echo: assert property (osc_pin_out |-> !$past(osc_pin_in))
    else $error("oscillator drive wrong");
endmodule // tmr8c_asserts

bind tmr8c_core tmr8c_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
  .count_at_top(count_at_top), .count_at_bottom(count_at_bottom));
`default_nettype wire

/* bench/timer8_counter_compare_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr8c_regs.vh"
module timer8_counter_compare_core_tb;
  logic pclk, presetn, psel, penable, pwrite, osc_pin_in;
  logic ack_overflow, ack_match_a, ack_match_b;
  logic [31:0] paddr, pwdata, prdata, seed;
  logic pready, pslverr, osc_pin_out, irq_overflow, irq_match_a, irq_match_b;
  logic compare_out_a, compare_out_b, count_at_top, count_at_bottom;
  logic [32:0] q_exp[$];
  logic [32:0] q_msk[$];
  int n_errors, num_checks;

  tmr8c_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .ack_overflow(ack_overflow), .ack_match_a(ack_match_a), .ack_match_b(ack_match_b),
    .irq_overflow(irq_overflow), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
    .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
    .count_at_top(count_at_top), .count_at_bottom(count_at_bottom));

  // ************************************
  // Clock, watchdog and helpers
  // ************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Run needs about 1300 cycles, so 25000 means a hang
  initial begin
    #100000;
    n_errors++;
    results();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
    num_checks++;
    if ((got & m) !== exp) begin
      n_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, got & m, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask

  // Every driver starts on a rising edge, so two never collide in one step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is judged at the rising edge, where the request is released too
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper data bits carry noise that the core must ignore
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    seed = lfsr(seed);
    apb(1'b1, a, {seed[31:8], v});
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m);
    q_exp.push_back({25'h0, e});
    q_msk.push_back({25'h1FFFFFF, m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Rising edges on the oscillator pin are the only ticks in async mode
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge pclk);
      osc_pin_in <= 1'b1;
      repeat (2) @(posedge pclk);
      osc_pin_in <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // Read answers are paired with the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q_exp.size() > 0) begin
      chk_rd({pslverr, prdata}, q_exp.pop_front(), q_msk.pop_front());
    end
  end

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [7:0] v;
    int n;
    {psel, penable, pwrite, osc_pin_in} = 4'h0;
    {ack_overflow, ack_match_a, ack_match_b} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    seed = 32'h7D6F;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd(32'(a), 8'h00, 8'hFF);
    q_exp.push_back({1'b1, 32'h0});
    q_msk.push_back({33{1'b1}});
    apb(1'b0, 32'h100, 32'h0);
    // Stopped counter keeps whatever software writes
    repeat (4) begin
      seed = lfsr(seed);
      v = seed[7:0];
      wr(`TMR8C_OFS_COUNT, v);
      repeat (20) @(posedge pclk);
      rd(`TMR8C_OFS_COUNT, v, 8'hFF);
    end
    // Extreme indications follow a stopped counter one cycle late
    wr(`TMR8C_OFS_COUNT, `TMR8C_MAX);
    settle();
    pin(count_at_top, 1'b1);
    pin(count_at_bottom, 1'b0);
    wr(`TMR8C_OFS_COUNT, `TMR8C_BOTTOM);
    settle();
    pin(count_at_bottom, 1'b1);
    pin(count_at_top, 1'b0);
    // Force strobes: toggle A twice, set then clear B, no flags
    wr(`TMR8C_OFS_CTRL_A, 8'h70);
    for (int i = 0; i < 2; i++) begin
      wr(`TMR8C_OFS_CTRL_B, 8'h80);
      settle();
      pin(compare_out_a, i == 0);
    end
    wr(`TMR8C_OFS_CTRL_B, 8'h40);
    settle();
    pin(compare_out_b, 1'b1);
    wr(`TMR8C_OFS_CTRL_A, 8'h20);
    wr(`TMR8C_OFS_CTRL_B, 8'h40);
    settle();
    pin(compare_out_b, 1'b0);
    rd(`TMR8C_OFS_FLAG, 8'h00, 8'hFF);
    // Counter write while stopped blocks the match on the first tick
    wr(`TMR8C_OFS_CTRL_A, 8'h00);
    wr(`TMR8C_OFS_CMP_B, 8'h30);
    wr(`TMR8C_OFS_MASK, 8'h07);
    wr(`TMR8C_OFS_COUNT, 8'h30);
    wr(`TMR8C_OFS_FLAG, 8'h07);
    wr(`TMR8C_OFS_CTRL_B, 8'h01);
    rd(`TMR8C_OFS_FLAG, 8'h00, 8'h04);
    wr(`TMR8C_OFS_COUNT, 8'h2F);
    // Match is seen one tick after the write and flagged one tick later
    repeat (2) @(posedge pclk);
    rd(`TMR8C_OFS_FLAG, 8'h04, 8'h04);
    settle();
    pin(irq_match_b, 1'b1);
    @(posedge pclk);
    ack_match_b <= 1'b1;
    @(posedge pclk);
    ack_match_b <= 1'b0;
    settle();
    pin(irq_match_b, 1'b0);
    wr(`TMR8C_OFS_COUNT, 8'h2F);
    wr(`TMR8C_OFS_FLAG, 8'h00);
    rd(`TMR8C_OFS_FLAG, 8'h04, 8'h04);
    wr(`TMR8C_OFS_FLAG, 8'h04);
    rd(`TMR8C_OFS_FLAG, 8'h00, 8'h04);
    // Wrap from the top sets overflow
    wr(`TMR8C_OFS_FLAG, 8'h01);
    wr(`TMR8C_OFS_COUNT, 8'hF0);
    n = 0;
    while (irq_overflow !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    pin(irq_overflow, 1'b1);
    rd(`TMR8C_OFS_COUNT, 8'h00, 8'hF0);
    wr(`TMR8C_OFS_COUNT, 8'h80);
    rd(`TMR8C_OFS_COUNT, 8'h80, 8'hF0);
    // Clear on compare keeps the count at or below compare A
    wr(`TMR8C_OFS_CMP_A, 8'h07);
    wr(`TMR8C_OFS_COUNT, 8'h00);
    wr(`TMR8C_OFS_CTRL_A, 8'h02);
    repeat (8) rd(`TMR8C_OFS_COUNT, 8'h00, 8'hF8);
    // Match A recurs every cycle of the sequence and is never cleared here
    pin(irq_match_a, 1'b1);
    // Power-off freezes ticks but not the registers
    wr(`TMR8C_OFS_POWER, 8'h01);
    wr(`TMR8C_OFS_COUNT, 8'h11);
    repeat (10) @(posedge pclk);
    rd(`TMR8C_OFS_COUNT, 8'h11, 8'hFF);
    wr(`TMR8C_OFS_POWER, 8'h00);
    // Async source: exactly one step per rising oscillator edge
    wr(`TMR8C_OFS_CTRL_A, 8'h00);
    wr(`TMR8C_OFS_ASYNC, 8'h01);
    wr(`TMR8C_OFS_COUNT, 8'h00);
    osc(5);
    rd(`TMR8C_OFS_COUNT, 8'h05, 8'hFF);
    // Fast PWM: new compare B waits in the buffer until TOP
    wr(`TMR8C_OFS_CTRL_A, 8'h03);
    wr(`TMR8C_OFS_CMP_B, 8'h40);
    rd(`TMR8C_OFS_CMP_B, 8'h40, 8'hFF);
    wr(`TMR8C_OFS_COUNT, 8'h2F);
    wr(`TMR8C_OFS_FLAG, 8'h07);
    osc(2);
    rd(`TMR8C_OFS_FLAG, 8'h04, 8'h04);
    osc(208);
    wr(`TMR8C_OFS_COUNT, 8'h3F);
    wr(`TMR8C_OFS_FLAG, 8'h07);
    osc(2);
    rd(`TMR8C_OFS_FLAG, 8'h04, 8'h04);
    @(posedge pclk);
    results();
  end
endmodule // timer8_counter_compare_core_tb
`default_nettype wire
